/* logic/tdf_fetch.sv */
// Descriptor chain fetch, decode, fragment walk and result update engine
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
`include "tdf_map.svh"
// Function
// RL1: Descriptors are 100 bytes, 8-byte aligned; the whole block is read.
// RL2: Each next descriptor is found through the pointer of the previous one.
// RL3: Word 0 holds a 31-bit unsigned destination card number.
// RL4: Byte 3 bit 7 set means the descriptor is not yet prepared.
// RL5: Word 0 is read first in every descriptor fetch.
// RL6: Word 4 is the service number; 00000001h is the registry.
// RL7: Major function 02h is an application transaction; others are reserved.
// RL8: Low two bytes of word 8 form the 16-bit minor function.
// RL9: Fields sit at byte offsets 0,4,8,12,28,44,60,76,80,96.
// RL10: Parameters of 16 bytes or less are inline at bytes 80-95.
// RL11: Longer parameters need one extra DMA read after the descriptor.
// RL12: The two low bits of the next pointer are cleared for addressing.
// RL13: Byte 96 bit 0 marks the end of chain; fetching stops there.
// RL14: Data descriptor: type, entry count, zero, address, offset, length.
// RL15: Types 0Bh none, 0Ch direct, 0Dh fragment list; others reserved.
// RL16: Entry count is used only for type 0Dh.
// RL17: Offset is a logical displacement across fragments, bounded by length.
// RL18: List entries are address then length pairs, 8 bytes each.
// RL19: Fragment addresses and lengths may be any byte value.
// RL20: Result word is 4-byte aligned: zero, network byte, application halfword.
// RL21: Network result is preset to 00h; written only on network error.
// RL22: Application result is preset to 0000h; written only on error.
// RL23: Doorbell bit is cleared before fetching from the last next pointer.
// RL24: Next fetch only if end flag and doorbell are 0; unprepared skipped.
// RL25: Reserved major function or type is a decode error; no data transfer.
module tdf_fetch
(
	input  wire logic                 mclk_in,
	input  wire logic                 resetn_in,
	input  wire logic [9:0]           avs_address_in,
	input  wire logic                 avs_read_in,
	input  wire logic                 avs_write_in,
	input  wire logic [31:0]          avs_writedata_in,
	input  wire logic [3:0]           avs_byteenable_in,
	output logic [31:0]               avs_readdata_out,
	output logic                      avs_waitrequest_out,
	output tdf_pkg::tdf_dma_req_t     dma_req_out,
	input  wire logic                 dma_waitrequest_in,
	input  wire logic [31:0]          dma_readdata_in,
	output logic                      desc_ready_out,
	output logic                      decode_error_out
);

	typedef struct packed {
		tdf_pkg::tdf_state_t           st;
		logic                          enable;
		logic                          doorbell;
		logic [31:0]                   link;
		logic [`TDF_DESC_WORDS-1:0][31:0] desc;
		logic [`TDF_PAR_WORDS-1:0][31:0]  par;
		logic [4:0]                    idx;
		logic [4:0]                    par_n;
		logic                          ready;
		logic                          unprep;
		logic                          derr;
		logic                          eoc;
		logic                          inline_par;
		logic                          walk_done;
		logic                          walk_fail;
		logic [1:0]                    walk_sel;
		logic [7:0]                    ent_i;
		logic                          ent_len;
		logic [31:0]                   ent_addr;
		logic [31:0]                   rem;
		logic [31:0]                   frag_addr;
		logic [31:0]                   frag_len;
		tdf_pkg::tdf_dma_req_t         dma;
		logic                          av_wait;
		logic [31:0]                   av_rdata;
	} tdf_regs_t;

	tdf_regs_t q;
	tdf_regs_t n;

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic type_ok(input logic [7:0] t);
		type_ok = (t == `TDF_TYPE_NONE) || (t == `TDF_TYPE_DIRECT) || (t == `TDF_TYPE_LIST);
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] w,
		input logic [3:0] be);
		be_merge = o;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				be_merge[i*8 +: 8] = w[i*8 +: 8];
		end
	endfunction

	function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
		umin = (a < b) ? a : b;
	endfunction

	// Word index of one field of data descriptor k (0 type word .. 3 length)
	function automatic logic [4:0] ddr_w(input logic [1:0] k, input logic [1:0] f);
		ddr_w = 5'(`TDF_W_DDR0) + {1'b0, k, 2'b00} + {3'b000, f};
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	logic        av_req;
	logic        av_wr;
	logic        dma_go;
	logic [31:0] rd_mux;
	logic [31:0] status;
	logic [31:0] plen;
	logic [4:0]  wsel;
	logic [31:0] wlen;

	always_comb
	begin
		n = q;
		av_req = avs_read_in | avs_write_in;
		av_wr = avs_write_in & ~q.av_wait;
		dma_go = (q.dma.read | q.dma.write) & ~dma_waitrequest_in;
		plen = q.desc[ddr_w(2'd0, 2'd3)];
		wsel = ddr_w(q.walk_sel, 2'd0);
		wlen = q.desc[wsel + 5'd3];
		status = 32'h00000000;
		status[`TDF_ST_BUSY] = (q.st != tdf_pkg::TDF_IDLE) && (q.st != tdf_pkg::TDF_HOLD);
		status[`TDF_ST_READY] = q.ready;
		status[`TDF_ST_UNPREP] = q.unprep;
		status[`TDF_ST_DECERR] = q.derr;
		status[`TDF_ST_EOC] = q.eoc;
		status[`TDF_ST_WDONE] = q.walk_done;
		status[`TDF_ST_WFAIL] = q.walk_fail;
		status[`TDF_ST_INLINE] = q.inline_par;

		// Register read mux; unmapped offsets read as zero
		rd_mux = 32'h00000000;
		if (avs_address_in >= `TDF_REG_PAR_BASE)
		begin
			if (avs_address_in[9:2] < 8'(`TDF_REG_PAR_BASE >> 2) + 8'(`TDF_PAR_WORDS))
				rd_mux = q.par[avs_address_in[5:2]];
		end
		else if (avs_address_in >= `TDF_REG_DESC_BASE)
		begin
			if (avs_address_in[7:2] < 6'(`TDF_DESC_WORDS))
				rd_mux = q.desc[avs_address_in[6:2]];
		end
		else
		begin
			case (avs_address_in)
				`TDF_REG_CTRL:      rd_mux = {29'h0000000, 1'b0, q.doorbell, q.enable};
				`TDF_REG_STATUS:    rd_mux = status;
				`TDF_REG_WALK:      rd_mux = {30'h00000000, q.walk_sel};
				`TDF_REG_FRAG_ADDR: rd_mux = q.frag_addr;
				`TDF_REG_FRAG_LEN:  rd_mux = q.frag_len;
				`TDF_REG_LINK:      rd_mux = q.link;
				// RL6 registry check
				// RL7 major function
				// RL8 minor function
				`TDF_REG_FUNC:      rd_mux = {7'h00,
					q.desc[`TDF_W_SERVICE] == `TDF_SVC_REGISTRY,
					q.desc[`TDF_W_FUNC][23:0]};
				// RL3 31-bit node
				`TDF_REG_NODE:      rd_mux = {1'b0, q.desc[`TDF_W_NODE][30:0]};
				`TDF_REG_SERVICE:   rd_mux = q.desc[`TDF_W_SERVICE];
				default:            rd_mux = 32'h00000000;
			endcase
		end

		// One wait cycle per access: the answer stands at the edge after the request
		n.av_wait = 1'b1;
		if (av_req && q.av_wait)
		begin
			n.av_wait = 1'b0;
			n.av_rdata = rd_mux;
		end

		////////////////////////////////////////////////////////////////////////////
		// Software writes; hardware sets below override clears
		if (av_wr && avs_address_in == `TDF_REG_CTRL)
		begin
			if (avs_byteenable_in[0])
			begin
				n.enable = avs_writedata_in[`TDF_CTRL_ENABLE];
				if (avs_writedata_in[`TDF_CTRL_DOORBELL])
					n.doorbell = 1'b1;
				if (avs_writedata_in[`TDF_CTRL_LOAD] && q.st == tdf_pkg::TDF_IDLE)
					n.link = q.link;
			end
		end
		if (av_wr && avs_address_in == `TDF_REG_START && q.st == tdf_pkg::TDF_IDLE)
			n.link = be_merge(q.link, avs_writedata_in, avs_byteenable_in);
		if (av_wr && avs_address_in == `TDF_REG_STATUS && avs_byteenable_in[0])
		begin
			if (avs_writedata_in[`TDF_ST_UNPREP])
				n.unprep = 1'b0;
			if (avs_writedata_in[`TDF_ST_DECERR])
				n.derr = 1'b0;
			if (avs_writedata_in[`TDF_ST_WDONE])
				n.walk_done = 1'b0;
			if (avs_writedata_in[`TDF_ST_WFAIL])
				n.walk_fail = 1'b0;
		end

		////////////////////////////////////////////////////////////////////////////
		case (q.st)
			tdf_pkg::TDF_IDLE:
			begin
				if (q.enable && q.doorbell)
				begin
					// RL23 clear doorbell first
					n.doorbell = 1'b0;
					// RL12 mask control bits
					n.dma.address = {q.link[31:2], 2'b00};
					n.dma.read = 1'b1;
					n.idx = 5'd0;
					n.st = tdf_pkg::TDF_FETCH;
				end
			end
			tdf_pkg::TDF_FETCH:
			begin
				if (dma_go)
				begin
					// RL5 word 0 first
					// RL9 word position
					n.desc[q.idx] = dma_readdata_in;
					n.dma.address = q.dma.address + 32'h00000004;
					n.idx = q.idx + 5'd1;
					// RL1 full 100 bytes
					if (q.idx == 5'(`TDF_DESC_WORDS - 1))
					begin
						n.dma.read = 1'b0;
						n.st = tdf_pkg::TDF_DECODE;
					end
				end
			end
			tdf_pkg::TDF_DECODE:
			begin
				// RL4 unprepared marker
				// RL24 skip unprepared
				if (q.desc[`TDF_W_NODE][`TDF_UNPREP_BIT])
				begin
					n.unprep = 1'b1;
					n.st = tdf_pkg::TDF_IDLE;
				end
				else
				begin
					// RL2 follow chain link
					n.link = q.desc[`TDF_W_LINK];
					// RL13 end of chain
					n.eoc = q.desc[`TDF_W_LINK][`TDF_EOC_BIT];
					n.inline_par = plen <= `TDF_INLINE_MAX;
					n.frag_addr = 32'h00000000;
					n.frag_len = 32'h00000000;
					n.walk_done = 1'b0;
					n.walk_fail = 1'b0;
					n.par = '0;
					// RL25 reserved codes
					// RL15 type check
					if (q.desc[`TDF_W_FUNC][23:16] != `TDF_MAJOR_APP
						|| !type_ok(q.desc[ddr_w(2'd0, 2'd0)][31:24])
						|| !type_ok(q.desc[ddr_w(2'd1, 2'd0)][31:24])
						|| !type_ok(q.desc[ddr_w(2'd2, 2'd0)][31:24])
						|| !type_ok(q.desc[ddr_w(2'd3, 2'd0)][31:24])
						|| (plen > `TDF_INLINE_MAX
						&& q.desc[ddr_w(2'd0, 2'd0)][31:24] != `TDF_TYPE_DIRECT))
					begin
						n.derr = 1'b1;
						n.ready = 1'b1;
						n.st = tdf_pkg::TDF_HOLD;
					end
					// RL10 inline parameters
					else if (plen <= `TDF_INLINE_MAX)
					begin
						for (int i = 0; i < 4; i++)
							n.par[i] = q.desc[`TDF_W_PARAM + i];
						n.ready = 1'b1;
						n.st = tdf_pkg::TDF_HOLD;
					end
					// RL11 extra parameter read
					else
					begin
						n.dma.address = (q.desc[ddr_w(2'd0, 2'd1)]
							+ q.desc[ddr_w(2'd0, 2'd2)]) & 32'hfffffffc;
						n.dma.read = 1'b1;
						n.idx = 5'd0;
						n.par_n = 5'(umin((plen + 32'h00000003) >> 2, 32'(`TDF_PAR_WORDS)));
						n.st = tdf_pkg::TDF_PARAM;
					end
				end
			end
			tdf_pkg::TDF_PARAM:
			begin
				if (dma_go)
				begin
					n.par[q.idx[3:0]] = dma_readdata_in;
					n.dma.address = q.dma.address + 32'h00000004;
					n.idx = q.idx + 5'd1;
					if (q.idx + 5'd1 == q.par_n)
					begin
						n.dma.read = 1'b0;
						n.ready = 1'b1;
						n.st = tdf_pkg::TDF_HOLD;
					end
				end
			end
			tdf_pkg::TDF_HOLD:
			begin
				if (av_wr && avs_address_in == `TDF_REG_STATUS && avs_byteenable_in[0]
					&& avs_writedata_in[`TDF_ST_READY])
				begin
					n.ready = 1'b0;
					// RL24 continue only if allowed
					if (!q.eoc && !q.doorbell && q.enable)
					begin
						n.dma.address = {q.link[31:2], 2'b00};
						n.dma.read = 1'b1;
						n.idx = 5'd0;
						n.st = tdf_pkg::TDF_FETCH;
					end
					else
						n.st = tdf_pkg::TDF_IDLE;
				end
				else if (av_wr && avs_address_in == `TDF_REG_WALK && !q.derr)
				begin
					n.walk_sel = avs_writedata_in[1:0];
					n.walk_done = 1'b0;
					n.walk_fail = 1'b0;
					n.st = tdf_pkg::TDF_WALK;
					n.ent_i = 8'h00;
					n.ent_len = 1'b0;
				end
				// RL20 result word
				// RL21 network byte only on error
				// RL22 application halfword only on error
				else if (av_wr && avs_address_in == `TDF_REG_RESULT
					&& avs_writedata_in[23:0] != 24'h000000)
				begin
					n.dma.address = {q.desc[`TDF_W_RESULT][31:2], 2'b00};
					n.dma.writedata = {8'h00, avs_writedata_in[23:0]};
					n.dma.write = 1'b1;
					n.st = tdf_pkg::TDF_RESULT;
				end
			end
			tdf_pkg::TDF_WALK:
			begin
				// RL14 descriptor layout
				// RL16 count only for lists
				if (q.desc[wsel][31:24] != `TDF_TYPE_LIST)
				begin
					// RL17 offset bounded by length
					n.frag_addr = q.desc[wsel + 5'd1] + q.desc[wsel + 5'd2];
					n.frag_len = (q.desc[wsel][31:24] == `TDF_TYPE_NONE) ? 32'h00000000 : wlen;
					n.walk_done = 1'b1;
					n.st = tdf_pkg::TDF_HOLD;
				end
				else if (!q.dma.read && !q.ent_len && q.ent_i == 8'h00 && q.idx != 5'h1f)
				begin
					// RL18 entry pairs
					n.dma.address = q.desc[wsel + 5'd1];
					n.dma.read = 1'b1;
					n.rem = q.desc[wsel + 5'd2];
					n.idx = 5'h1f;
					if (q.desc[wsel][23:16] == 8'h00)
					begin
						n.dma.read = 1'b0;
						n.walk_fail = 1'b1;
						n.idx = 5'd0;
						n.st = tdf_pkg::TDF_HOLD;
					end
				end
				else if (dma_go)
				begin
					n.dma.address = q.dma.address + 32'h00000004;
					n.ent_len = ~q.ent_len;
					if (!q.ent_len)
						n.ent_addr = dma_readdata_in;
					// RL19 byte granular fragments
					else if (q.rem < dma_readdata_in)
					begin
						n.frag_addr = q.ent_addr + q.rem;
						n.frag_len = umin(dma_readdata_in - q.rem, wlen);
						n.walk_done = 1'b1;
						n.dma.read = 1'b0;
						n.idx = 5'd0;
						n.st = tdf_pkg::TDF_HOLD;
					end
					else
					begin
						n.rem = q.rem - dma_readdata_in;
						n.ent_i = q.ent_i + 8'h01;
						if (q.ent_i + 8'h01 == q.desc[wsel][23:16])
						begin
							n.walk_fail = 1'b1;
							n.dma.read = 1'b0;
							n.idx = 5'd0;
							n.st = tdf_pkg::TDF_HOLD;
						end
					end
				end
			end
			tdf_pkg::TDF_RESULT:
			begin
				if (dma_go)
				begin
					n.dma.write = 1'b0;
					n.st = tdf_pkg::TDF_HOLD;
				end
			end
			default:
			begin
				n.st = tdf_pkg::TDF_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			q <= '0;
			q.av_wait <= 1'b1;
			q.st <= tdf_pkg::TDF_IDLE;
		end
		else
			q <= n;
	end

	assign avs_readdata_out = q.av_rdata;
	assign avs_waitrequest_out = q.av_wait;
	assign dma_req_out = q.dma;
	assign desc_ready_out = q.ready;
	assign decode_error_out = q.derr;

endmodule

/* logic/tdf_map.svh */
// Offsets, field positions and codes for the transaction descriptor fetch block
`ifndef TDF_MAP_SVH
`define TDF_MAP_SVH
// Register byte offsets on the Avalon slave
`define TDF_REG_CTRL      10'h000
`define TDF_REG_START     10'h004
`define TDF_REG_STATUS    10'h008
`define TDF_REG_RESULT    10'h00c
`define TDF_REG_WALK      10'h010
`define TDF_REG_FRAG_ADDR 10'h014
`define TDF_REG_FRAG_LEN  10'h018
`define TDF_REG_LINK      10'h01c
`define TDF_REG_FUNC      10'h020
`define TDF_REG_NODE      10'h024
`define TDF_REG_SERVICE   10'h028
`define TDF_REG_DESC_BASE 10'h100
`define TDF_REG_PAR_BASE  10'h200
// Control bits
`define TDF_CTRL_ENABLE   0
`define TDF_CTRL_DOORBELL 1
`define TDF_CTRL_LOAD     2
// Status bits
`define TDF_ST_BUSY       0
`define TDF_ST_READY      1
`define TDF_ST_UNPREP     2
`define TDF_ST_DECERR     3
`define TDF_ST_EOC        4
`define TDF_ST_WDONE      5
`define TDF_ST_WFAIL      6
`define TDF_ST_INLINE     7
// Descriptor layout, in 32-bit words
`define TDF_DESC_WORDS    25
`define TDF_W_NODE        0
`define TDF_W_SERVICE     1
`define TDF_W_FUNC        2
`define TDF_W_DDR0        3
`define TDF_W_RESULT      19
`define TDF_W_PARAM       20
`define TDF_W_LINK        24
`define TDF_UNPREP_BIT    31
`define TDF_EOC_BIT       0
// Codes
`define TDF_MAJOR_APP     8'h02
`define TDF_SVC_REGISTRY  32'h00000001
`define TDF_TYPE_NONE     8'h0b
`define TDF_TYPE_DIRECT   8'h0c
`define TDF_TYPE_LIST     8'h0d
`define TDF_INLINE_MAX    32'h00000010
`define TDF_PAR_WORDS     16
`endif

/* logic/tdf_pkg.sv */
// Types shared by the transaction descriptor fetch block
package tdf_pkg;
	typedef enum logic [2:0] {
		TDF_IDLE,
		TDF_FETCH,
		TDF_DECODE,
		TDF_PARAM,
		TDF_HOLD,
		TDF_WALK,
		TDF_RESULT
	} tdf_state_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [31:0] address;
		logic [31:0] writedata;
	} tdf_dma_req_t;
endpackage

/* tb/tdf_fetch_sva.sv */
// Port assertions for the descriptor fetch engine
`timescale 1ns/10ps
module tdf_fetch_sva
(
	input wire logic                  mclk_in,
	input wire logic                  resetn_in,
	input wire logic                  avs_read_in,
	input wire logic                  avs_write_in,
	input wire logic                  avs_waitrequest_out,
	input wire tdf_pkg::tdf_dma_req_t dma_req_out,
	input wire logic                  dma_waitrequest_in,
	input wire logic                  desc_ready_out,
	input wire logic                  decode_error_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	bus_answer_a: assert property (
		(avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("register access not answered in one cycle");
	bus_pulse_a: assert property (
		!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("register answer longer than one cycle");
	dma_excl_a: assert property (
		!(dma_req_out.read && dma_req_out.write))
		else $error("dma read and write together");
	dma_hold_a: assert property (
		(dma_req_out.read || dma_req_out.write) && dma_waitrequest_in |=> $stable(dma_req_out))
		else $error("dma request changed while stalled");
	read_align_a: assert property (
		dma_req_out.read |-> dma_req_out.address[1:0] == 2'b00)
		else $error("dma read address not word aligned");
	burst_step_a: assert property (
		dma_req_out.read && !dma_waitrequest_in ##1 dma_req_out.read
		|-> dma_req_out.address == $past(dma_req_out.address) + 32'h4)
		else $error("dma read address did not step by four");
	result_word_a: assert property (
		dma_req_out.write |-> dma_req_out.writedata[31:24] == 8'h00
		&& dma_req_out.address[1:0] == 2'b00)
		else $error("result word malformed");
	err_sticky_a: assert property (
		decode_error_out && !avs_write_in |=> decode_error_out)
		else $error("decode error dropped without a clear");
	cover property ($rose(desc_ready_out));
	cover property ($rose(decode_error_out));
	cover property (dma_req_out.write && !dma_waitrequest_in);
endmodule
bind tdf_fetch tdf_fetch_sva u_sva (.mclk_in(mclk_in), .resetn_in(resetn_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_waitrequest_out(avs_waitrequest_out), .dma_req_out(dma_req_out),
	.dma_waitrequest_in(dma_waitrequest_in), .desc_ready_out(desc_ready_out),
	.decode_error_out(decode_error_out));

/* tb/tdf_fetch_tb.sv */
// Self-checking bench for the descriptor fetch engine
`timescale 1ns/10ps
`include "tdf_map.svh"
module tdf_fetch_tb;
	localparam logic [31:0] ALL = 32'hffffffff;
	// Host images: head block, list, result word
	localparam logic [31:0] TAB [0:41] = '{32'h1004, 32'h1, 32'h100c, 32'h0c000000,
		32'h1010, 32'h8000, 32'h1018, 32'h14, 32'h101c, 32'h0d020000, 32'h1020, 32'h4000,
		32'h1024, 32'h5, 32'h1028, 32'h40, 32'h102c, 32'h0c000000, 32'h1030, 32'h7001,
		32'h1034, 32'h3, 32'h1038, 32'h14, 32'h103c, 32'h0b000000, 32'h104c, 32'h3000,
		32'h1060, 32'h1068, 32'h1068, 32'h80000000, 32'h4000, 32'h5003, 32'h4004, 32'h3,
		32'h4008, 32'h6001, 32'h400c, 32'h32, 32'h3000, 32'h0};
	localparam logic [31:0] WEXP [1:3] = '{32'h6003, 32'h7004, 32'h0};
	logic                  mclk_in = 1'b0;
	logic                  resetn_in = 1'b0;
	logic [9:0]            avs_address_in = 10'h000;
	logic                  avs_read_in = 1'b0;
	logic                  avs_write_in = 1'b0;
	logic [31:0]           avs_writedata_in = 32'h0;
	logic [31:0]           avs_readdata_out;
	logic                  avs_waitrequest_out;
	tdf_pkg::tdf_dma_req_t dma_req_out;
	logic                  dma_waitrequest_in;
	logic [31:0]           dma_readdata_in;
	logic                  desc_ready_out;
	logic                  decode_error_out;
	logic                  want = 1'b0;
	logic [31:0]           eq[$];
	logic [31:0]           mq[$];
	logic [31:0]           rdv;
	logic [31:0]           nd;
	logic [31:0]           mn;
	logic [31:0]           pw;
	logic [31:0]           rs;
	int                    n0;
	int                    mismatches = 0;
	int                    total_checks = 0;

	always #4 mclk_in = ~mclk_in;

	tdf_fetch u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.dma_req_out(dma_req_out), .dma_waitrequest_in(dma_waitrequest_in),
		.dma_readdata_in(dma_readdata_in), .desc_ready_out(desc_ready_out),
		.decode_error_out(decode_error_out));
	tdf_host_mem u_host (.clk_in(mclk_in), .resetn_in(resetn_in), .req_in(dma_req_out),
		.wait_out(dma_waitrequest_in), .rdata_out(dma_readdata_in));
	////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task test_done;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task bus(input logic rd, input logic [9:0] a, input logic [31:0] d, input logic w);
		int n;
		n = 0;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_read_in <= rd;
		avs_write_in <= !rd;
		want <= w;
		do
		begin
			@(posedge mclk_in);
			n++;
		end
		while (avs_waitrequest_out !== 1'b0 && n < 100);
		if (n >= 100)
			mismatches++;
		rdv = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		want <= 1'b0;
		@(posedge mclk_in);
	endtask

	task wr(input logic [9:0] a, input logic [31:0] d);
		bus(1'b0, a, d, 1'b0);
	endtask

	task rc(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
		mq.push_back(m);
		eq.push_back(e);
		bus(1'b1, a, 32'h0, 1'b1);
	endtask

	task poll(input logic [31:0] m);
		for (int k = 0; k < 100; k++)
		begin
			bus(1'b1, `TDF_REG_STATUS, 32'h0, 1'b0);
			if ((rdv & m) != 32'h0)
				break;
		end
	endtask

	task put(input logic [31:0] a, input logic [31:0] d);
		u_host.mem[a[31:2]] = d;
	endtask
	////////////////////////////////
	always @(posedge mclk_in)
	begin
		if (avs_read_in && want && avs_waitrequest_out === 1'b0)
			chk(avs_readdata_out & mq.pop_front(), eq.pop_front());
		if (dma_req_out.write === 1'b1 && dma_waitrequest_in === 1'b0)
			chk(dma_req_out.writedata & mq.pop_front(), eq.pop_front());
	end

	initial
	begin
		#400000;
		mismatches++;
		test_done;
	end
	////////////////////////////////
	initial
	begin
		nd = $urandom(68);
		repeat (4) @(posedge mclk_in);
		resetn_in <= 1'b1;
		@(posedge mclk_in);
		for (int i = 0; i < 51; i++)
			put(32'h1000 + i * 4, 32'h0);
		for (int i = 0; i < 42; i += 2)
			put(TAB[i], TAB[i + 1]);
		nd = $urandom & 32'h7fffffff;
		mn = $urandom & 32'hffff;
		pw = $urandom;
		put(32'h1000, nd);
		put(32'h1008, {16'h0002, mn[15:0]});
		put(32'h8010, pw);
		rc(10'h3fc, ALL, 32'h0);
		wr(`TDF_REG_START, 32'h1000);
		wr(`TDF_REG_CTRL, 32'h3);
		poll(32'h2);
		chk(desc_ready_out, 1'b1);
		rc(`TDF_REG_NODE, ALL, nd);
		rc(`TDF_REG_SERVICE, ALL, 32'h1);
		rc(`TDF_REG_FUNC, ALL, {8'h01, 8'h02, mn[15:0]});
		rc(`TDF_REG_LINK, ALL, 32'h1068);
		rc(`TDF_REG_DESC_BASE + 10'h060, ALL, 32'h1068);
		rc(`TDF_REG_PAR_BASE + 10'h010, ALL, pw);
		rc(`TDF_REG_STATUS, 32'h80, 32'h0);
		chk(u_host.reads, 30);
		for (int i = 1; i < 4; i++)
		begin
			wr(`TDF_REG_WALK, i);
			poll(32'h60);
			if (i == 1)
				rc(`TDF_REG_STATUS, 32'h60, 32'h20);
			rc(i == 3 ? `TDF_REG_FRAG_LEN : `TDF_REG_FRAG_ADDR, ALL, WEXP[i]);
			wr(`TDF_REG_STATUS, 32'h60);
		end
		// Top byte stays clear; low bits forced nonzero so the write is not skipped
		rs = ($urandom & 32'h00ffffff) | 32'h1;
		mq.push_back(ALL);
		eq.push_back(rs);
		wr(`TDF_REG_RESULT, rs);
		repeat (100)
			if (eq.size() != 0)
				@(posedge mclk_in);
		// Let the memory model finish its write at the taking edge
		@(posedge mclk_in);
		chk(u_host.mem[30'h0c00], rs);
		n0 = u_host.reads;
		wr(`TDF_REG_STATUS, 32'h2);
		poll(32'h4);
		rc(`TDF_REG_STATUS, 32'h7, 32'h4);
		chk(u_host.reads - n0, 25);
		put(32'h1068, 32'h0);
		put(32'h1070, 32'h00050000);
		put(32'h10c8, 32'h10d1);
		wr(`TDF_REG_STATUS, 32'h4);
		n0 = u_host.reads;
		wr(`TDF_REG_CTRL, 32'h3);
		poll(32'ha);
		rc(`TDF_REG_STATUS, 32'h18, 32'h18);
		rc(`TDF_REG_LINK, ALL, 32'h10d1);
		rc(`TDF_REG_CTRL, 32'h2, 32'h0);
		chk(decode_error_out, 1'b1);
		wr(`TDF_REG_WALK, 32'h1);
		wr(`TDF_REG_STATUS, 32'h2);
		repeat (30) @(posedge mclk_in);
		chk(u_host.reads - n0, 25);
		rc(`TDF_REG_STATUS, 32'h1, 32'h0);
		wr(`TDF_REG_STATUS, 32'h8);
		chk(decode_error_out, 1'b0);
		test_done;
	end
endmodule

/* tb/tdf_host_mem.sv */
// Host memory model answering the engine's dma requests
`timescale 1ns/10ps
module tdf_host_mem
(
	input  wire logic                  clk_in,
	input  wire logic                  resetn_in,
	input  wire tdf_pkg::tdf_dma_req_t req_in,
	output logic                       wait_out,
	output logic [31:0]                rdata_out
);
	logic [31:0] mem [logic [29:0]];
	logic [31:0] last_q;
	int          reads;
	////////////////////////////////
	function automatic logic [31:0] peek(input logic [31:0] a);
		return mem.exists(a[31:2]) ? mem[a[31:2]] : 32'h5a5a5a5a;
	endfunction
	// Outside a taken read the data is inverted, so stale words never match
	assign rdata_out = (req_in.read && !wait_out) ? peek(req_in.address) : ~last_q;
	// Any address served, stalls at random
	always @(posedge clk_in or negedge resetn_in)
		if (!resetn_in)
		begin
			wait_out <= 1'b1;
			last_q <= 32'h0;
			reads <= 0;
		end
		else
		begin
			wait_out <= ($urandom % 3) == 0;
			if (req_in.write && !wait_out)
				mem[req_in.address[31:2]] = req_in.writedata;
			if (req_in.read && !wait_out)
			begin
				reads <= reads + 1;
				last_q <= rdata_out;
			end
		end
endmodule
